// *** hw/fcp_top.sv ***
// Four channel PWM block with shared period, time base and Avalon-MM slave.
// Assumes one clock, a synchronous reset and an asynchronous sleep request.
`timescale 1ns/1ps
module fcp_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic sleepReq,
   output logic [fcp_pkg::FCP_NUM_CH-1:0] pwmOut,
   output logic [fcp_pkg::FCP_NUM_CH-1:0] pwmPinOe
);
   import fcp_pkg::*;

   fcp_state_t s_q;
   fcp_state_t s_d;
   logic tick;
   logic wrap;
   logic wr;
   logic [FCP_TB_W-1:0] tbNext;
   logic [7:0] rdVal;
   logic [FCP_NUM_CH-1:0] chActive;

   function automatic logic [7:0] regAddr(input logic [7:0] base,
                                          input int idx);
      return base + 8'(idx * 4);
   endfunction : regAddr

   for (genvar g = 0; g < FCP_NUM_CH; g++) begin : gCh
      fcp_channel uChan (
         .clk(clk),
         .rst_n(rst_n),
         .tick(tick),
         .wrap(wrap),
         .tbNext(tbNext),
         .dutyBuf({s_q.dutyH[g], s_q.dutyL[g]}),
         .active(chActive[g])
      );
   end

   always_comb begin
      s_d = s_q;
      // The second sleep flop is the only reader of the first.
      s_d.sleep1 = sleepReq;
      s_d.sleep2 = s_q.sleep1;

      // Time base: the prescaler runs on clk so the rate follows clk.
      // A compare at or above the last value keeps a prescale change that
      // shortens the count from stalling the time base for 64 clocks.
      tick = s_q.timerOn && !s_q.sleep2
             && s_q.preCnt >= fcp_presc_last(s_q.presc);
      wrap = 1'b0;
      if (s_q.timerOn && !s_q.sleep2) begin
         s_d.preCnt = tick ? 6'h00 : s_q.preCnt + 6'h01;
      end
      if (tick) begin
         s_d.quarter = s_q.quarter + 2'h1;
         if (s_q.quarter == 2'h3) begin
            if (s_q.count == s_q.period) begin
               s_d.count = 8'h00;
               wrap = 1'b1;
            end else begin
               s_d.count = s_q.count + 8'h01;
            end
         end
      end
      tbNext = {s_d.count, s_d.quarter};

      // One wait state: the request is answered in the following cycle.
      wr = avs_write && s_q.ack && avs_byteenable[0];
      s_d.ack = (avs_read || avs_write) && !s_q.ack;

      rdVal = 8'h00;
      if (avs_address == FCP_PERIOD_OFF) begin
         rdVal = s_q.period;
      end else if (avs_address == FCP_TCTRL_OFF) begin
         rdVal = {5'h00, s_q.timerOn, s_q.presc};
      end else if (avs_address == FCP_COUNT_OFF) begin
         rdVal = s_q.count;
      end else if (avs_address == FCP_FLAG_OFF) begin
         rdVal = {6'h00, s_q.flag, 1'b0};
      end else if (avs_address == FCP_DIR_OFF) begin
         rdVal = {4'h0, s_q.dir};
      end
      for (int i = 0; i < FCP_NUM_CH; i++) begin
         if (avs_address == regAddr(FCP_CTRL_BASE, i)) begin
            rdVal = {s_q.en[i], s_q.oe[i], s_q.level[i], s_q.pol[i],
                     4'h0};
         end else if (avs_address == regAddr(FCP_DUTYH_BASE, i)) begin
            rdVal = s_q.dutyH[i];
         end else if (avs_address == regAddr(FCP_DUTYL_BASE, i)) begin
            rdVal = {s_q.dutyL[i], 6'h00};
         end
      end
      if (avs_read && !s_q.ack) begin
         s_d.rdata = rdVal;
      end

      if (wr) begin
         if (avs_address == FCP_PERIOD_OFF) begin
            s_d.period = avs_writedata[7:0];
         end else if (avs_address == FCP_TCTRL_OFF) begin
            s_d.timerOn = avs_writedata[FCP_TON_BIT];
            s_d.presc = avs_writedata[1:0];
         end else if (avs_address == FCP_DIR_OFF) begin
            s_d.dir = avs_writedata[3:0];
         end
         for (int i = 0; i < FCP_NUM_CH; i++) begin
            if (avs_address == regAddr(FCP_CTRL_BASE, i)) begin
               s_d.en[i] = avs_writedata[FCP_EN_BIT];
               s_d.oe[i] = avs_writedata[FCP_OE_BIT];
               s_d.pol[i] = avs_writedata[FCP_POL_BIT];
            end else if (avs_address == regAddr(FCP_DUTYH_BASE, i)) begin
               s_d.dutyH[i] = avs_writedata[7:0];
            end else if (avs_address == regAddr(FCP_DUTYL_BASE, i)) begin
               s_d.dutyL[i] = avs_writedata[7:FCP_DCL_LSB];
            end
         end
      end

      // A match in the cycle of a clearing write still sets the flag.
      if (wrap) begin
         s_d.flag = 1'b1;
      end else if (wr && avs_address == FCP_FLAG_OFF
                   && !avs_writedata[FCP_FLAG_BIT]) begin
         s_d.flag = 1'b0;
      end

      // Asleep, pins keep their level; a disabled channel shows polarity.
      if (!s_q.sleep2) begin
         for (int i = 0; i < FCP_NUM_CH; i++) begin
            s_d.level[i] = s_q.en[i] ? (chActive[i] ^ s_q.pol[i])
                                     : s_q.pol[i];
         end
      end
      s_d.pinOe = s_q.oe & ~s_q.dir;

      // Duty registers keep their contents through reset.
      if (!rst_n) begin
         s_d = '0;
         s_d.dutyH = s_q.dutyH;
         s_d.dutyL = s_q.dutyL;
         s_d.en = FCP_CTRL_RST;
         s_d.oe = FCP_CTRL_RST;
         s_d.pol = FCP_CTRL_RST;
         s_d.period = FCP_PERIOD_RST;
         s_d.presc = FCP_PRESC_RST;
         s_d.dir = FCP_DIR_RST;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign avs_readdata = {24'h000000, s_q.rdata};
   assign avs_waitrequest = !s_q.ack;
   assign pwmOut = s_q.level;
   assign pwmPinOe = s_q.pinOe;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_reset_inputs: assert property (disable iff (1'b0)
      !rst_n |=> (pwmPinOe == 4'h0 && s_q.dir == 4'hf
                  && s_q.en == 4'h0))
      else $error("Reset did not release pins and clear control.");
   chk_pin_release: assert property (
      (!s_q.oe[0] || s_q.dir[0]) |=> !pwmPinOe[0])
      else $error("Pin driven while output enable is clear.");
   chk_disabled_level: assert property (
      (!s_q.en[1] && !s_q.sleep2) |=> pwmOut[1] == $past(s_q.pol[1]))
      else $error("Disabled channel not at inactive level.");
   chk_enabled_level: assert property (
      (s_q.en[0] && !s_q.sleep2)
      |=> pwmOut[0] == $past(chActive[0] ^ s_q.pol[0]))
      else $error("Enabled channel level wrong.");
   chk_period_wrap: assert property (
      (tick && s_q.quarter == 2'h3 && s_q.count == s_q.period)
      |=> (s_q.count == 8'h00 && s_q.quarter == 2'h0 && s_q.flag))
      else $error("Time base did not wrap at period match.");
   chk_sleep_hold: assert property (
      s_q.sleep2 |=> ($stable(s_q.count) && $stable(s_q.quarter)
                      && $stable(pwmOut)))
      else $error("Time base or pin moved while asleep.");
   chk_ctrl_read: assert property (
      (avs_read && !s_q.ack && avs_address == FCP_CTRL_BASE)
      |=> (avs_readdata[3:0] == 4'h0 && !avs_waitrequest
           && avs_readdata[5] == $past(pwmOut[0])))
      else $error("Control read back wrong.");
   chk_duty_low_read: assert property (
      (avs_read && !s_q.ack && avs_address == FCP_DUTYL_BASE)
      |=> avs_readdata[5:0] == 6'h00)
      else $error("Duty low unused bits not zero.");
   chk_prescale_rate: assert property (
      (s_q.timerOn && s_q.presc == 2'h1 && !s_q.sleep2 && tick)
      ##1 (s_q.timerOn && !s_q.sleep2 && $stable(s_q.presc)) [*3]
      |=> tick)
      else $error("Prescaled tick spacing wrong.");

   cov_wrap: cover property (wrap);
   cov_write: cover property (wr && avs_address == FCP_CTRL_BASE);
   cov_pin_toggle: cover property (pwmPinOe[0] && $rose(pwmOut[0]));
endmodule : fcp_top

// *** hw/fcp_pkg.sv ***
// Package for the four channel PWM block: register map, field positions,
// reset values and the state types of the channel and top modules.
// Assumes a 32-bit Avalon-MM master that addresses bytes, one word per
// register.
package fcp_pkg;
   localparam int FCP_NUM_CH = 4;
   localparam int FCP_TB_W = 10;
   // Byte addresses; the per-channel registers step by one word.
   localparam logic [7:0] FCP_CTRL_BASE = 8'h00;
   localparam logic [7:0] FCP_DUTYH_BASE = 8'h10;
   localparam logic [7:0] FCP_DUTYL_BASE = 8'h20;
   localparam logic [7:0] FCP_PERIOD_OFF = 8'h30;
   localparam logic [7:0] FCP_TCTRL_OFF = 8'h34;
   localparam logic [7:0] FCP_COUNT_OFF = 8'h38;
   localparam logic [7:0] FCP_FLAG_OFF = 8'h3c;
   localparam logic [7:0] FCP_DIR_OFF = 8'h40;
   // Field positions.
   localparam int FCP_EN_BIT = 7;
   localparam int FCP_OE_BIT = 6;
   localparam int FCP_OUT_BIT = 5;
   localparam int FCP_POL_BIT = 4;
   localparam int FCP_DCL_LSB = 6;
   localparam int FCP_TON_BIT = 2;
   localparam int FCP_FLAG_BIT = 1;
   // Values after reset.
   localparam logic [3:0] FCP_CTRL_RST = 4'h0;
   localparam logic [7:0] FCP_PERIOD_RST = 8'hff;
   localparam logic [3:0] FCP_DIR_RST = 4'hf;
   localparam logic [1:0] FCP_PRESC_RST = 2'h0;

   // Last value of the prescale counter for 1, 4, 16 and 64 clocks.
   function automatic logic [5:0] fcp_presc_last(input logic [1:0] sel);
      case (sel)
         2'h0: return 6'h00;
         2'h1: return 6'h03;
         2'h2: return 6'h0f;
         default: return 6'h3f;
      endcase
   endfunction : fcp_presc_last

   typedef struct packed {
      logic active;
      logic [FCP_TB_W-1:0] duty;
   } fcp_chan_t;

   typedef struct packed {
      logic [FCP_NUM_CH-1:0] en;
      logic [FCP_NUM_CH-1:0] oe;
      logic [FCP_NUM_CH-1:0] pol;
      logic [FCP_NUM_CH-1:0][7:0] dutyH;
      logic [FCP_NUM_CH-1:0][1:0] dutyL;
      logic [7:0] period;
      logic timerOn;
      logic [1:0] presc;
      logic [5:0] preCnt;
      logic [7:0] count;
      logic [1:0] quarter;
      logic flag;
      logic [FCP_NUM_CH-1:0] dir;
      logic [FCP_NUM_CH-1:0] level;
      logic [FCP_NUM_CH-1:0] pinOe;
      logic sleep1;
      logic sleep2;
      logic ack;
      logic [7:0] rdata;
   } fcp_state_t;
endpackage : fcp_pkg

// *** hw/fcp_channel.sv ***
// One PWM channel: buffered duty value and the raw active/inactive state.
// Assumes tick, wrap and tbNext come from the shared time base on clk.
`timescale 1ns/1ps
module fcp_channel (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic wrap,
   input wire logic [fcp_pkg::FCP_TB_W-1:0] tbNext,
   input wire logic [fcp_pkg::FCP_TB_W-1:0] dutyBuf,
   output logic active
);
   import fcp_pkg::*;

   fcp_chan_t s_q;
   fcp_chan_t s_d;

   always_comb begin
      s_d = s_q;
      if (wrap) begin
         s_d.duty = dutyBuf;
         s_d.active = (dutyBuf != 10'h000);
      end else if (tick && tbNext == s_q.duty) begin
         s_d.active = 1'b0;
      end
      if (!rst_n) begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign active = s_q.active;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_duty_latch: assert property (wrap |=> s_q.duty == $past(dutyBuf))
      else $error("Duty buffer not latched at time base wrap.");
   chk_duty_clear: assert property (
      (tick && !wrap && tbNext == s_q.duty) |=> !s_q.active)
      else $error("Output not cleared at duty match.");
   chk_wrap_start: assert property (
      (wrap && dutyBuf != 10'h000) |=> s_q.active)
      else $error("Output not active after time base wrap.");
   cov_full_pulse: cover property (s_q.active ##1 !s_q.active);
endmodule : fcp_channel

// *** tb/fcp_pin_model.sv ***
// Port pad model at the far side of the four PWM outputs.
// Assumes a weak pull-up on every pad that no channel drives.
`timescale 1ns/1ps
module fcp_pin_model (
   input wire logic [fcp_pkg::FCP_NUM_CH-1:0] pinOe,
   input wire logic [fcp_pkg::FCP_NUM_CH-1:0] level,
   output logic [fcp_pkg::FCP_NUM_CH-1:0] pad
);
   import fcp_pkg::*;
   // A released pad floats up, so a stale driven low never lingers.
   always_comb begin
      for (int i = 0; i < FCP_NUM_CH; i++) begin
         pad[i] = pinOe[i] ? level[i] : 1'b1;
      end
   end
endmodule : fcp_pin_model

// *** tb/four_channel_pwm_output_bench.sv ***
// Self-checking bench for the four channel PWM block.
// Assumes the one-wait-cycle Avalon-MM slave of fcp_top.
`timescale 1ns/1ps
module four_channel_pwm_output_bench;
   import fcp_pkg::*;
   typedef struct {logic [7:0] a, w, r;} fcp_reg_row_t;
   typedef struct {logic [7:0] dh, dl, ctl, tc; int n, hi;} fcp_pwm_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic sleepReq = 1'b0;
   logic [3:0] pwmOut, pwmPinOe, pad;
   int miscompares = 0;
   int cmpCount = 0;
   int cycles = 0;
   int h;
   logic [7:0] q, c;
   fcp_reg_row_t regs[5] = '{'{8'h10, 8'ha5, 8'ha5}, '{8'h2c, 8'hff, 8'hc0},
      '{8'h08, 8'h2f, 8'h00}, '{8'h04, 8'h1f, 8'h30}, '{8'h44, 8'hff, 8'h00}};
   fcp_pwm_row_t pwms[7] = '{'{8'h0, 8'h80, 8'hc0, 8'h4, 40, 20},
      '{8'h0, 8'h40, 8'hc0, 8'h4, 40, 10}, '{8'h0, 8'h40, 8'hd0, 8'h4, 40, 30},
      '{8'h0, 8'h00, 8'hc0, 8'h4, 40, 0}, '{8'h1, 8'h00, 8'hc0, 8'h4, 40, 40},
      '{8'h0, 8'h40, 8'hc0, 8'h5, 160, 40},
      '{8'h1, 8'h00, 8'h50, 8'h4, 40, 40}};

   fcp_top dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sleepReq(sleepReq), .pwmOut(pwmOut), .pwmPinOe(pwmPinOe));
   fcp_pin_model pins (.pinOe(pwmPinOe), .level(pwmOut), .pad(pad));

   always #4 clk = ~clk;

   task automatic give_verdict();
      if (miscompares == 0 && cmpCount > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   // The hang limit is far above the thousand or so cycles the run needs.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
      cmpCount++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask : chk

   // Called just after a rising edge; returns one edge after release.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] rd);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, d};
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input string what, input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, q);
      chk(what, e, q);
   endtask : rd

   task automatic resetChecks();
      chk("pin oe", 8'h00, {4'h0, pwmPinOe});
      chk("pwm out", 8'h00, {4'h0, pwmOut});
      for (int i = 0; i < FCP_NUM_CH; i++) begin
         rd("ctrl", FCP_CTRL_BASE + 8'(4 * i), 8'h00);
      end
      rd("period", FCP_PERIOD_OFF, 8'hff);
      rd("dir", FCP_DIR_OFF, 8'h0f);
   endtask : resetChecks

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      resetChecks();
      foreach (regs[i]) begin
         wr(regs[i].a, regs[i].w);
         rd("reg", regs[i].a, regs[i].r);
      end
      rd("count", FCP_COUNT_OFF, 8'h00);
      wr(FCP_DIR_OFF, 8'h0f);
      wr(FCP_CTRL_BASE, 8'h00);
      wr(FCP_PERIOD_OFF, 8'h00);
      wr(FCP_DUTYH_BASE, 8'h00);
      wr(FCP_DUTYL_BASE, 8'h00);
      wr(FCP_FLAG_OFF, 8'h00);
      wr(FCP_TCTRL_OFF, 8'h04);
      h = 0;
      do begin
         bus(1'b0, FCP_FLAG_OFF, 8'h00, q);
         h++;
      end while (q[FCP_FLAG_BIT] !== 1'b1 && h < 50);
      chk("flag", 8'h02, q & 8'h02);
      wr(FCP_DIR_OFF, 8'h0e);
      wr(FCP_CTRL_BASE, 8'h40);
      // The pin enable is registered one cycle after the write lands.
      @(posedge clk);
      chk("pin oe", 8'h01, {4'h0, pwmPinOe} & 8'h01);
      foreach (pwms[i]) begin
         wr(FCP_DUTYH_BASE, pwms[i].dh);
         wr(FCP_DUTYL_BASE, pwms[i].dl);
         wr(FCP_CTRL_BASE, pwms[i].ctl);
         wr(FCP_TCTRL_OFF, pwms[i].tc);
         repeat (40) @(posedge clk);
         h = 0;
         repeat (pwms[i].n) begin
            @(posedge clk);
            if (pwmOut[0] === 1'b1) h++;
         end
         chk("high cycles", 8'(pwms[i].hi), 8'(h));
         chk("pad", {7'h0, pwmOut[0]}, {7'h0, pad[0]});
      end
      // A channel kept for on-chip use only releases its pad.
      wr(FCP_CTRL_BASE, 8'h90);
      @(posedge clk);
      chk("released pad", 8'h01, {7'h0, pad[0]});
      chk("pin oe", 8'h00, {4'h0, pwmPinOe} & 8'h01);
      wr(FCP_PERIOD_OFF, 8'h40);
      repeat (20) @(posedge clk);
      sleepReq <= 1'b1;
      repeat (4) @(posedge clk);
      bus(1'b0, FCP_COUNT_OFF, 8'h00, c);
      repeat (30) @(posedge clk);
      rd("sleep count", FCP_COUNT_OFF, c);
      sleepReq <= 1'b0;
      repeat (40) @(posedge clk);
      bus(1'b0, FCP_COUNT_OFF, 8'h00, q);
      chk("wake count moves", 8'h01, 8'(q !== c));
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      resetChecks();
      rd("duty kept", FCP_DUTYH_BASE, pwms[6].dh);
      give_verdict();
   end
endmodule : four_channel_pwm_output_bench
